//--- include/irq_pkg.sv
// Shared constants, types and helpers for the interrupt controller
package irq_pkg;

  // ------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------
  localparam int NUM_SRC = 11;          // Interrupt sources
  localparam int NUM_LVL = 4;           // Priority levels
  localparam int MC_CLOCKS = 4;         // Clocks per machine cycle
  localparam int CALL_MCS = 4;          // Long call length, cycles
  localparam int CALL_CLOCKS = CALL_MCS * MC_CLOCKS;
  localparam int MAX_LAT_MCS = 12;      // Worst response, cycles
  localparam int MAX_LAT_CLOCKS = MAX_LAT_MCS * MC_CLOCKS;

  // ------------------------------------------------------------
  // Source index equals arbitration rank (0 wins ties)
  // ------------------------------------------------------------
  localparam int SRC_EXT0 = 0;
  localparam int SRC_BO = 1;
  localparam int SRC_WD = 2;
  localparam int SRC_T0 = 3;
  localparam int SRC_TW = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_KB = 6;
  localparam int SRC_T1 = 7;
  localparam int SRC_UART = 8;
  localparam int SRC_T2 = 9;
  localparam int SRC_CAP = 10;

  // ------------------------------------------------------------
  // Bit positions in enable and priority registers
  // ------------------------------------------------------------
  localparam int EN_EXT0 = 0;           // First register group
  localparam int EN_T0 = 1;
  localparam int EN_EXT1 = 2;
  localparam int EN_T1 = 3;
  localparam int EN_UART = 4;
  localparam int EN_T2 = 5;
  localparam int EN_GLOBAL = 7;
  localparam int EN_TW = 0;             // Extended register group
  localparam int EN_KB = 1;
  localparam int EN_WD = 4;
  localparam int EN_BO = 6;
  localparam int EN_CAP = 7;

  // Vector addresses by source index
  localparam logic [15:0] VEC [NUM_SRC] = '{
    16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h0013,
    16'h003B, 16'h001B, 16'h0023, 16'h0043, 16'h006B};

  // Sources able to wake from power-down
  localparam logic [10:0] WAKE_MASK = 11'h067;
  // Reset value of the in-service set
  localparam logic [3:0] SVC_NONE = 4'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef logic [1:0] level_t;
  typedef enum logic [3:0] {
    PH_C1 = 4'h1, PH_C2 = 4'h2, PH_C3 = 4'h4, PH_C4 = 4'h8
  } phase_t;
  typedef enum logic [1:0] {
    CALL_IDLE = 2'h1, CALL_RUN = 2'h2
  } call_state_t;

  // Highest level in service as {valid, level}
  function automatic logic [2:0] svc_top(input logic [3:0] svc);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < NUM_LVL; i++)
      if (svc[i]) r = {1'b1, 2'(i)};
    return r;
  endfunction

endpackage

//--- include/irq_arb_if.sv
// Carrier between the controller and its priority arbiter
interface irq_arb_if;
  import irq_pkg::*;
  logic [10:0] req;           // Gated, polled requests
  level_t lvl [NUM_SRC];      // Level of each source
  logic [3:0] in_service;     // Levels now in service
  logic win_valid;            // A request may vector now
  logic [3:0] win_idx;        // Winning source
  level_t win_lvl;            // Winning level
  modport ctrl (output req, lvl, in_service,
                input win_valid, win_idx, win_lvl);
  modport arb (input req, lvl, in_service,
               output win_valid, win_idx, win_lvl);
endinterface

//--- logic/irq_ext_input.sv
// External interrupt pin synchroniser and request flag
module irq_ext_input
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Pin and mode
  input wire logic pin_i,
  input wire logic trigger_type_i,
  // Strobes
  input wire logic sample_c3_i,
  input wire logic hw_clear_i,
  input wire logic sw_clear_i,
  // Flag
  output logic flag_o
);

  logic [2:0] sync;           // Three-stage pin chain
  logic stable;               // Agreed pin level
  logic prev;                 // Previous C3 sample
  logic [2:0] next_sync;
  logic next_stable;
  logic next_prev;
  logic next_flag;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_sync = {sync[1:0], pin_i};
    // Accept a change once stages two and three agree
    next_stable = (sync[1] == sync[2]) ? sync[2] : stable;
    next_prev = prev;
    next_flag = flag_o;
    // Vectoring clears only in edge mode
    if ((hw_clear_i && trigger_type_i) || sw_clear_i)
      next_flag = 1'b0;
    if (sample_c3_i)
    begin
      next_prev = stable;
      if (trigger_type_i)
      begin
        // Edge mode: high sample then low sample
        if (prev && !stable)
          next_flag = 1'b1;
      end
      else
        next_flag = !stable;
    end
  end

  // Registers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync <= 3'h7;
      stable <= 1'b1;
      prev <= 1'b1;
      flag_o <= 1'b0;
    end
    else
    begin
      sync <= next_sync;
      stable <= next_stable;
      prev <= next_prev;
      flag_o <= next_flag;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_edge_sets_flag: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    sample_c3_i && trigger_type_i && prev && !stable |=> flag_o)
    else $error("edge did not set flag");
  a_level_follows: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    sample_c3_i && !trigger_type_i |=> flag_o == !$past(stable))
    else $error("level flag not following pin");

endmodule // irq_ext_input

//--- logic/irq_arbiter.sv
// Priority resolution among polled requests
module irq_arbiter
  import irq_pkg::*;
(
  irq_arb_if.arb bus
);

  logic [2:0] top;            // Highest level in service

  // ------------------------------------------------------------
  // Pick highest level above service; lowest index wins ties
  // ------------------------------------------------------------
  always_comb
  begin
    top = svc_top(bus.in_service);
    bus.win_valid = 1'b0;
    bus.win_idx = 4'h0;
    bus.win_lvl = 2'h0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      // Strictly above current service only
      if (bus.req[i] && (!top[2] || bus.lvl[i] > top[1:0]))
      begin
        // Later equal level never displaces earlier rank
        if (!bus.win_valid || bus.lvl[i] > bus.win_lvl)
        begin
          bus.win_valid = 1'b1;
          bus.win_idx = 4'(i);
          bus.win_lvl = bus.lvl[i];
        end
      end
    end
  end

endmodule // irq_arbiter

//--- logic/irq_controller.sv
// Four-level interrupt controller, top level
module irq_controller
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // External pins and trigger types
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic ext0_trigger_type_i,
  input wire logic ext1_trigger_type_i,
  // Timer overflow events and software flag clears
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic [3:0] flag_clear_i,
  // Peripheral flags
  input wire logic brownout_flag_i,
  input wire logic watchdog_timeout_flag_i,
  input wire logic twowire_status_flag_i,
  input wire logic twowire_timeout_flag_i,
  input wire logic keypad_flag_i,
  input wire logic uart_receive_flag_i,
  input wire logic uart_transmit_flag_i,
  input wire logic timer2_event_flag_i,
  input wire logic timer2_external_flag_i,
  input wire logic capture_event_flag_i,
  input wire logic watchdog_rc_clock_i,
  // Enable and priority registers
  input wire logic [7:0] enable_register_one_i,
  input wire logic [7:0] extended_enable_register_i,
  input wire logic [7:0] priority_low_bits_group_a_i,
  input wire logic [7:0] priority_high_bits_group_a_i,
  input wire logic [7:0] priority_low_bits_group_b_i,
  input wire logic [7:0] priority_high_bits_group_b_i,
  // Core status
  input wire logic last_cycle_i,
  input wire logic reg_write_or_exit_i,
  input wire logic interrupt_exit_i,
  // Flags back to the core
  output logic ext0_request_flag_o,
  output logic ext1_request_flag_o,
  output logic timer0_overflow_flag_o,
  output logic timer1_overflow_flag_o,
  // Call to the core
  output logic machine_cycle_start_o,
  output logic hardware_long_call_o,
  output logic push_pc_o,
  output logic [15:0] vector_o,
  // Status
  output logic [3:0] in_service_o,
  output logic wake_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  irq_arb_if arb_bus ();      // To and from the arbiter

  phase_t phase;              // Clock within machine cycle
  phase_t next_phase;
  call_state_t call_state;    // Long call sequencer
  call_state_t next_call_state;
  logic [4:0] call_cnt;       // Clocks left in the call
  logic [4:0] next_call_cnt;
  logic [15:0] next_vector;
  logic next_push;
  logic [3:0] next_svc;
  logic next_t0;
  logic next_t1;
  logic [10:0] raw_req;       // Flags after OR and enables
  logic [10:0] polled;        // Snapshot of the previous machine cycle
  logic [10:0] next_polled;
  logic take;                 // Vector in this clock
  logic clr_t0;               // Hardware clear of timer flags
  logic clr_t1;
  logic clr_e0;               // Hardware clear of pin flags
  logic clr_e1;
  logic global_en;
  logic [2:0] svc_hi;         // Highest level in service, {valid, level}

  // ------------------------------------------------------------
  // External pin flags
  // ------------------------------------------------------------
  irq_ext_input u_ext0 (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_irq_pin_a_i),
    .trigger_type_i(ext0_trigger_type_i),
    .sample_c3_i(phase == PH_C3),
    .hw_clear_i(clr_e0),
    .sw_clear_i(flag_clear_i[0]),
    .flag_o(ext0_request_flag_o)
  );

  irq_ext_input u_ext1 (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_irq_pin_b_i),
    .trigger_type_i(ext1_trigger_type_i),
    .sample_c3_i(phase == PH_C3),
    .hw_clear_i(clr_e1),
    .sw_clear_i(flag_clear_i[1]),
    .flag_o(ext1_request_flag_o)
  );

  // ------------------------------------------------------------
  // Request gating, multi-flag sources combined first
  // ------------------------------------------------------------
  assign global_en = enable_register_one_i[EN_GLOBAL];

  always_comb
  begin
    raw_req = 11'h000;
    raw_req[SRC_EXT0] = ext0_request_flag_o
      && enable_register_one_i[EN_EXT0];
    raw_req[SRC_BO] = brownout_flag_i
      && extended_enable_register_i[EN_BO];
    raw_req[SRC_WD] = watchdog_timeout_flag_i
      && extended_enable_register_i[EN_WD];
    raw_req[SRC_T0] = timer0_overflow_flag_o
      && enable_register_one_i[EN_T0];
    raw_req[SRC_TW] = (twowire_status_flag_i
      || twowire_timeout_flag_i)
      && extended_enable_register_i[EN_TW];
    raw_req[SRC_EXT1] = ext1_request_flag_o
      && enable_register_one_i[EN_EXT1];
    raw_req[SRC_KB] = keypad_flag_i
      && extended_enable_register_i[EN_KB];
    raw_req[SRC_T1] = timer1_overflow_flag_o
      && enable_register_one_i[EN_T1];
    raw_req[SRC_UART] = (uart_receive_flag_i
      || uart_transmit_flag_i)
      && enable_register_one_i[EN_UART];
    raw_req[SRC_T2] = (timer2_event_flag_i
      || timer2_external_flag_i)
      && enable_register_one_i[EN_T2];
    raw_req[SRC_CAP] = capture_event_flag_i
      && extended_enable_register_i[EN_CAP];
    if (!global_en)
      raw_req = 11'h000;
  end

  // Levels: high bit and low bit at the same position
  always_comb
  begin
    arb_bus.lvl[SRC_EXT0] = {priority_high_bits_group_a_i[EN_EXT0],
      priority_low_bits_group_a_i[EN_EXT0]};
    arb_bus.lvl[SRC_T0] = {priority_high_bits_group_a_i[EN_T0],
      priority_low_bits_group_a_i[EN_T0]};
    arb_bus.lvl[SRC_EXT1] = {priority_high_bits_group_a_i[EN_EXT1],
      priority_low_bits_group_a_i[EN_EXT1]};
    arb_bus.lvl[SRC_T1] = {priority_high_bits_group_a_i[EN_T1],
      priority_low_bits_group_a_i[EN_T1]};
    arb_bus.lvl[SRC_UART] = {priority_high_bits_group_a_i[EN_UART],
      priority_low_bits_group_a_i[EN_UART]};
    arb_bus.lvl[SRC_T2] = {priority_high_bits_group_a_i[EN_T2],
      priority_low_bits_group_a_i[EN_T2]};
    arb_bus.lvl[SRC_TW] = {priority_high_bits_group_b_i[EN_TW],
      priority_low_bits_group_b_i[EN_TW]};
    arb_bus.lvl[SRC_KB] = {priority_high_bits_group_b_i[EN_KB],
      priority_low_bits_group_b_i[EN_KB]};
    arb_bus.lvl[SRC_WD] = {priority_high_bits_group_b_i[EN_WD],
      priority_low_bits_group_b_i[EN_WD]};
    arb_bus.lvl[SRC_BO] = {priority_high_bits_group_b_i[EN_BO],
      priority_low_bits_group_b_i[EN_BO]};
    arb_bus.lvl[SRC_CAP] = {priority_high_bits_group_b_i[EN_CAP],
      priority_low_bits_group_b_i[EN_CAP]};
  end

  assign arb_bus.req = polled;
  assign arb_bus.in_service = in_service_o;
  assign svc_hi = svc_top(in_service_o);

  irq_arbiter u_arb (
    .bus(arb_bus)
  );

  // Wake request: enabled wake-capable flags, ungated by polling
  always_comb
  begin
    logic [10:0] w;
    w = raw_req & WAKE_MASK;
    // Watchdog wakes only on the internal RC clock
    w[SRC_WD] = w[SRC_WD] && watchdog_rc_clock_i;
    wake_o = |w;
  end

  // ------------------------------------------------------------
  // Vectoring decision
  // ------------------------------------------------------------
  // Last clock of an unblocked final instruction cycle
  assign take = (phase == PH_C4) && (call_state == CALL_IDLE)
    && last_cycle_i && !reg_write_or_exit_i
    && arb_bus.win_valid;

  // Only timer and edge-mode pin flags are cleared here
  assign clr_t0 = take && (arb_bus.win_idx == 4'(SRC_T0));
  assign clr_t1 = take && (arb_bus.win_idx == 4'(SRC_T1));
  assign clr_e0 = take && (arb_bus.win_idx == 4'(SRC_EXT0));
  assign clr_e1 = take && (arb_bus.win_idx == 4'(SRC_EXT1));

  // ------------------------------------------------------------
  // Next state of phase, poll, flags, call and service
  // ------------------------------------------------------------
  always_comb
  begin
    // Machine cycle phase ring
    case (phase)
      PH_C1: next_phase = PH_C2;
      PH_C2: next_phase = PH_C3;
      PH_C3: next_phase = PH_C4;
      PH_C4: next_phase = PH_C1;
      default: next_phase = PH_C1;
    endcase
    // Fresh snapshot each cycle; nothing carried over
    next_polled = (phase == PH_C4) ? raw_req : polled;
    if (take)
      next_polled = 11'h000;
    // Timer flags: set wins over any clear
    next_t0 = timer0_overflow_flag_o;
    next_t1 = timer1_overflow_flag_o;
    if (clr_t0 || flag_clear_i[2])
      next_t0 = 1'b0;
    if (clr_t1 || flag_clear_i[3])
      next_t1 = 1'b0;
    if (timer0_overflow_i)
      next_t0 = 1'b1;
    if (timer1_overflow_i)
      next_t1 = 1'b1;
    // Call sequencer
    next_call_state = call_state;
    next_call_cnt = call_cnt;
    next_vector = vector_o;
    next_push = 1'b0;
    case (call_state)
      CALL_IDLE:
      begin
        if (take)
        begin
          next_call_state = CALL_RUN;
          next_call_cnt = 5'(CALL_CLOCKS - 1);
          next_vector = VEC[arb_bus.win_idx];
          next_push = 1'b1;
        end
      end
      CALL_RUN:
      begin
        if (call_cnt == 5'h00)
          next_call_state = CALL_IDLE;
        else
          next_call_cnt = call_cnt - 5'h01;
      end
      default: next_call_state = CALL_IDLE;
    endcase
    // In-service set: exit clears top bit, vectoring sets one
    next_svc = in_service_o;
    if (interrupt_exit_i && svc_hi[2])
      next_svc[svc_hi[1:0]] = 1'b0;
    if (take)
      next_svc[arb_bus.win_lvl] = 1'b1;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase <= PH_C1;
      polled <= 11'h000;
      timer0_overflow_flag_o <= 1'b0;
      timer1_overflow_flag_o <= 1'b0;
      call_state <= CALL_IDLE;
      call_cnt <= 5'h00;
      vector_o <= 16'h0000;
      push_pc_o <= 1'b0;
      in_service_o <= SVC_NONE;
    end
    else
    begin
      phase <= next_phase;
      polled <= next_polled;
      timer0_overflow_flag_o <= next_t0;
      timer1_overflow_flag_o <= next_t1;
      call_state <= next_call_state;
      call_cnt <= next_call_cnt;
      vector_o <= next_vector;
      push_pc_o <= next_push;
      in_service_o <= next_svc;
    end
  end

  assign machine_cycle_start_o = (phase == PH_C1);
  assign hardware_long_call_o = (call_state == CALL_RUN);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_call_four_cycles: assert property (
    $rose(hardware_long_call_o) |-> ##15 hardware_long_call_o
      ##1 !hardware_long_call_o)
    else $error("long call length wrong");
  a_call_at_end: assert property (
    $rose(hardware_long_call_o) |-> $past(last_cycle_i)
      && !$past(reg_write_or_exit_i) && machine_cycle_start_o)
    else $error("call outside instruction end");
  a_strict_preempt: assert property (
    $rose(hardware_long_call_o) |->
      svc_top(in_service_o) > svc_top($past(in_service_o)))
    else $error("preempted by equal or lower level");
  a_vector_match: assert property (
    take |=> vector_o == VEC[$past(arb_bus.win_idx)] && push_pc_o)
    else $error("wrong vector");
  a_timer_cleared: assert property (
    clr_t0 && !timer0_overflow_i |=> !timer0_overflow_flag_o)
    else $error("timer flag not cleared");
  a_exit_pops: assert property (
    interrupt_exit_i && !take && in_service_o != SVC_NONE |=>
      $countones(in_service_o) == $countones($past(in_service_o)) - 1)
    else $error("exit did not end service");
  a_global_off: assert property (
    !global_en && phase == PH_C4 |=> !arb_bus.win_valid)
    else $error("request with global enable off");
  a_rank_ext0: assert property (
    arb_bus.win_valid && polled[SRC_EXT0]
      && arb_bus.lvl[SRC_EXT0] == arb_bus.win_lvl
      |-> arb_bus.win_idx == 4'(SRC_EXT0))
    else $error("tie not won by top rank");
  a_fresh_poll: assert property (
    phase == PH_C4 && !take |=> polled == $past(raw_req))
    else $error("poll kept stale request");

endmodule // irq_controller

//--- sim/cpu_core_model.sv
// Behavioural processor core that paces instructions for the controller
module cpu_core_model
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Cycle start from the controller, commands from the bench
  input wire logic mc_start_i,
  input wire logic [2:0] len_i,
  input wire logic block_i,
  input wire logic exit_i,
  // Status to the controller
  output logic last_cycle_o,
  output logic reg_write_or_exit_o,
  output logic interrupt_exit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mc_idx; // Machine cycle within the instruction
  // ----------------------------------------
  // Instruction pacing, one to seven cycles
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
      mc_idx <= 3'h0;
    else if (mc_start_i)
      mc_idx <= last_cycle_o ? 3'h0 : mc_idx + 3'h1;
  assign last_cycle_o = (mc_idx + 3'h1 >= len_i);
  // Register writes and exits hold off a call
  assign reg_write_or_exit_o = last_cycle_o & (block_i | exit_i);
  assign interrupt_exit_o = exit_i;
endmodule // cpu_core_model

//--- sim/tb_top.sv
// Self-checking bench for the interrupt controller
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_pkg::*;
  // Register bit of each source, group b at 8 and up
  localparam int P [11] = '{0, 14, 12, 1, 8, 2, 9, 3, 4, 5, 15};
  localparam logic [15:0] V [11] = '{16'h0003, 16'h002B, 16'h0053,
    16'h000B, 16'h0033, 16'h0013, 16'h003B, 16'h001B, 16'h0023,
    16'h0043, 16'h006B};
  localparam logic [10:0] W = 11'h067; // Wake-capable sources
  logic mclk_i, rst_b_i, pa, pb, tt0, rc, alt, t0p, t1p, blk, ex, hold;
  logic last, blkd, exi, mcs, call, push, f0, f1, ft0, ft1, wake;
  logic [4:0] fx; // Expected flags and wake after a single-source call
  logic [10:0] fl;
  logic [15:0] en, pl, ph, vec;
  logic [3:0] svc, insvc, fc;
  logic [2:0] len;
  logic [31:0] xs = 32'h0000_002F;
  logic [19:0] exp_q [$];
  logic [19:0] qe;
  int mismatches, comparisons;
  irq_controller uut (
    .mclk_i, .rst_b_i, .ext_irq_pin_a_i(pa), .ext_irq_pin_b_i(pb),
    .ext0_trigger_type_i(tt0), .ext1_trigger_type_i(tt0),
    .timer0_overflow_i(t0p), .timer1_overflow_i(t1p),
    .flag_clear_i(fc), .brownout_flag_i(fl[1]),
    .watchdog_timeout_flag_i(fl[2]), .twowire_status_flag_i(fl[4] & alt),
    .twowire_timeout_flag_i(fl[4] & ~alt), .keypad_flag_i(fl[6]),
    .uart_receive_flag_i(fl[8] & alt), .uart_transmit_flag_i(fl[8] & ~alt),
    .timer2_event_flag_i(fl[9] & alt), .timer2_external_flag_i(fl[9] & ~alt),
    .capture_event_flag_i(fl[10]), .watchdog_rc_clock_i(rc),
    .enable_register_one_i(en[7:0]), .extended_enable_register_i(en[15:8]),
    .priority_low_bits_group_a_i(pl[7:0]),
    .priority_high_bits_group_a_i(ph[7:0]),
    .priority_low_bits_group_b_i(pl[15:8]),
    .priority_high_bits_group_b_i(ph[15:8]),
    .last_cycle_i(last), .reg_write_or_exit_i(blkd),
    .interrupt_exit_i(exi), .ext0_request_flag_o(f0),
    .ext1_request_flag_o(f1), .timer0_overflow_flag_o(ft0),
    .timer1_overflow_flag_o(ft1), .machine_cycle_start_o(mcs),
    .hardware_long_call_o(call), .push_pc_o(push), .vector_o(vec),
    .in_service_o(insvc), .wake_o(wake));
  cpu_core_model core (.mclk_i, .rst_b_i, .mc_start_i(mcs), .len_i(len),
    .block_i(blk | hold), .exit_i(ex), .last_cycle_o(last),
    .reg_write_or_exit_o(blkd), .interrupt_exit_o(exi));
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction
  function automatic int lv(int s);
    return int'({ph[P[s]], pl[P[s]]});
  endfunction
  // Expected {valid, in-service, vector} for a request set
  function automatic logic [20:0] pick(logic [10:0] r);
    int b, t;
    b = -1;
    t = -1;
    for (int i = 0; i < 4; i++)
      if (svc[i]) t = i;
    for (int s = 0; s < 11; s++)
      if (r[s] && en[P[s]] && (b < 0 || lv(s) > lv(b))) b = s;
    if (b < 0 || !en[7] || blk || lv(b) <= t) return 21'h0;
    return {1'b1, svc | 4'(1 << lv(b)), V[b]};
  endfunction
  task automatic cfg(logic [10:0] e, logic [21:0] l, logic g);
    for (int s = 0; s < 11; s++)
    begin
      en[P[s]] = e[s];
      {ph[P[s]], pl[P[s]]} = l[2*s +: 2];
    end
    en[7] = g;
  endtask
  // Raise request set; level pins low, timers pulsed
  // Calls are held off until the slower pin flags have been polled too
  task automatic req(logic [10:0] r);
    void'(rnd());
    hold = 1'b1;
    alt = xs[0];
    pa = ~r[0];
    pb = ~r[5];
    fl = r;
    t0p = r[3];
    t1p = r[7];
    @(negedge mclk_i);
    t0p = 1'b0;
    t1p = 1'b0;
    repeat (12) @(negedge mclk_i);
    hold = 1'b0;
  endtask
  task automatic trial(logic [10:0] r);
    logic [20:0] w;
    int n;
    w = pick(r);
    if (w[20]) exp_q.push_back(w[19:0]);
    if (w[20]) svc = w[19:16];
    req(r);
    n = 0;
    while (call !== 1'b1 && n < MAX_LAT_CLOCKS)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (w[20]) `CHK(n < MAX_LAT_CLOCKS, 1'b1)
    n = 0;
    while (call === 1'b1 && n < 40)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (w[20]) `CHK(n, CALL_CLOCKS)
  endtask
  task automatic leave();
    int t;
    for (int i = 0; i < 4; i++)
      if (svc[i]) t = i;
    svc[t] = 1'b0;
    ex = 1'b1;
    @(negedge mclk_i);
    ex = 1'b0;
    @(negedge mclk_i);
    `CHK(insvc, svc)
  endtask
  task automatic settle();
    req(11'h0);
    // Software clears leave no flag behind for the next scenario
    fc = 4'hF;
    @(negedge mclk_i);
    fc = 4'h0;
    repeat (8) @(negedge mclk_i);
    `CHK({f0, f1, ft0, ft1}, 4'h0)
    while (svc != 4'h0) leave();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Each call is matched against the oldest expectation
  always @(negedge mclk_i)
    if (push === 1'b1)
    begin
      qe = exp_q.size() ? exp_q.pop_front() : 20'hF_FFFF;
      `CHK({insvc, vec}, qe)
    end
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial
  begin
    #80_000;
    mismatches++;
    close_out();
  end
  initial
  begin
    {rst_b_i, t0p, t1p, blk, ex, hold, tt0, rc, fl, en, pl, ph, svc} = '0;
    fc = 4'h0;
    {pa, pb, alt, len} = 6'h39;
    repeat (5) @(negedge mclk_i);
    rst_b_i = 1'b1;
    // Each source alone; both pins at once in edge mode, ext0 wins
    cfg(11'h7FF, 22'h0, 1'b1);
    for (int s = 0; s < 12; s++)
    begin
      tt0 = (s == 11);
      rc = ~rc;
      repeat (8) @(negedge mclk_i);
      trial(s == 11 ? 11'h021 : 11'h001 << s);
      // Edge-mode ext1 flag stays pending behind the level in service
      fx = {s == 0, s == 5 || s == 11, 2'b00,
        s == 11 || W[s % 11] && (s != 2 || rc)};
      `CHK({f0, f1, ft0, ft1}, fx[4:1])
      `CHK(wake, fx[0])
      settle();
    end
    tt0 = 1'b0;
    // Nested service, equal level held off
    cfg(11'h7FF, 22'h139, 1'b1);
    trial(11'h001);
    trial(11'h011);
    trial(11'h013);
    trial(11'h017);
    trial(11'h777);
    settle();
    // Blocked instruction, request gone before unblock
    blk = 1'b1;
    trial(11'h010);
    req(11'h0);
    repeat (8) @(negedge mclk_i);
    blk = 1'b0;
    repeat (16) @(negedge mclk_i);
    for (int k = 0; k < 8; k++)
    begin
      len = 3'(k % 3 + 1);
      cfg(11'(rnd()), 22'(rnd()), rnd() % 4 != 0);
      trial(11'(rnd()) & 11'h777);
      settle();
    end
    `CHK(exp_q.size(), 0)
    close_out();
  end
endmodule // tb_top
